// File: pkg/ddpp_pkg.sv
// constants, field layout and carrier types of the converter post-processing block
`default_nettype none
package ddpp_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int FS_HZ  = 48_000;
  localparam int FS_DIV = CLK_HZ / FS_HZ;
  localparam int RAMP_FAST_DIV = 2;
  localparam int RAMP_SLOW_DIV = 32;

  localparam logic [7:0] REG_BIAS = 8'h08;
  localparam logic [7:0] REG_DIG  = 8'h21;
  localparam logic [7:0] REG_VOL  = 8'h22;
  localparam logic [7:0] REG_ENA  = 8'h23;
  localparam logic [7:0] REG_STAT = 8'h24;

  localparam int DIG_MONO_BIT   = 12;
  localparam int DIG_SBF_BIT    = 11;
  localparam int DIG_RATE_BIT   = 10;
  localparam int DIG_MODE_BIT   = 9;
  localparam int DIG_MUTE_BIT   = 3;
  localparam int DIG_DEEMPHASIS_RATE_SELECT_LSB = 1;
  localparam int DIG_OSR_BIT    = 0;
  localparam int BIAS_BOOST_BIT = 5;
  localparam int BIAS_SEL_LSB   = 3;
  localparam int BIAS_VMID_LSB  = 1;
  localparam int VOL_LEFT_LSB   = 0;
  localparam int VOL_RIGHT_LSB  = 8;
  localparam int ENA_LEFT_BIT   = 1;
  localparam int ENA_RIGHT_BIT  = 0;

  localparam logic [15:0] DIG_RST  = 16'h0000;
  localparam logic [15:0] BIAS_RST = 16'h0000;
  localparam logic [15:0] VOL_RST  = 16'hc0c0;
  localparam logic [15:0] ENA_RST  = 16'h0003;
  localparam logic [7:0]  VOL_UNITY = 8'hc0;
  localparam logic [7:0]  VOL_SILENT = 8'h00;

  // per-mille of normal bias for select codes 00, 01, 10, 11
  localparam logic [11:0] BIAS_PERMILLE [4] = '{12'h3e8, 12'h1f4, 12'h294, 12'h2ee};
  // gain of 0..15 steps of 0.375 dB as a 16-bit fraction; each 16 steps is one more halving
  localparam logic [15:0] GAIN_MANT [16] = '{16'hffff, 16'hf52f, 16'head2, 16'he0e7, 16'hd766, 16'hce4c,
                                             16'hc594, 16'hbd3a, 16'hb53c, 16'had93, 16'ha63d, 16'h9f37,
                                             16'h987d, 16'h920b, 16'h8be0, 16'h85f7};

  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
  } ddpp_sample_t;

  typedef struct packed {
    logic       boost;
    logic [1:0] converter_bias_level;
    logic [1:0] midrail_buffer_bias_level;
  } ddpp_bias_t;
endpackage : ddpp_pkg
`default_nettype wire

// File: hdl/ddpp_ramp.sv
// one channel of soft mute volume ramping
`default_nettype none
module ddpp_ramp #(
  parameter logic [7:0] RST_CODE = ddpp_pkg::VOL_UNITY
) (
  input  wire logic       clk,                // system clock
  input  wire logic       rst_n,              // async reset, low
  input  wire logic       tick,               // ramp step enable
  input  wire logic       mute,               // soft mute control
  input  wire logic       unmute_ramp_select, // ramp on un-mute
  input  wire logic [7:0] target,             // programmed volume
  output logic      [7:0] applied             // volume in use
);
  typedef struct packed {
    logic [7:0] code;
  } ddpp_ramp_st_t;

  ddpp_ramp_st_t s_q;
  ddpp_ramp_st_t s_d;

  always_comb begin
    s_d = s_q;
    if (mute) begin
      if (tick && s_q.code != ddpp_pkg::VOL_SILENT) begin
        s_d.code = s_q.code - 8'h01;
      end
    end else if (!unmute_ramp_select) begin
      s_d.code = target;
    end else if (tick && s_q.code < target) begin
      s_d.code = s_q.code + 8'h01;
    end else if (tick && s_q.code > target) begin
      s_d.code = s_q.code - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.code <= RST_CODE;
    end else begin
      s_q <= s_d;
    end
  end

  assign applied = s_q.code;
endmodule : ddpp_ramp
`default_nettype wire

// File: hdl/ddpp_buf.sv
// small fifo holding processed sample pairs toward the converter
`default_nettype none
module ddpp_buf #(
  parameter int W     = 32,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,       // system clock
  input  wire logic         rst_n,     // async reset, low
  input  wire logic         in_valid,  // word offered
  output logic              in_ready,  // room for a word
  input  wire logic [W-1:0] in_data,   // word in
  output logic              out_valid, // word held
  input  wire logic         out_ready, // receiver takes word
  output logic      [W-1:0] out_data   // oldest word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [AW:0]             count;
  } ddpp_buf_st_t;

  ddpp_buf_st_t s_q;
  ddpp_buf_st_t s_d;
  logic         push;
  logic         pop;

  assign in_ready  = (s_q.count != (AW+1)'(DEPTH));
  assign out_valid = (s_q.count != '0);
  assign out_data  = s_q.mem[s_q.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr_ptr] = in_data;
      s_d.wr_ptr = (s_q.wr_ptr == AW'(DEPTH-1)) ? '0 : s_q.wr_ptr + AW'(1);
    end
    if (pop) begin
      s_d.rd_ptr = (s_q.rd_ptr == AW'(DEPTH-1)) ? '0 : s_q.rd_ptr + AW'(1);
    end
    case ({push, pop})
      2'b10:   s_d.count = s_q.count + (AW+1)'(1);
      2'b01:   s_d.count = s_q.count - (AW+1)'(1);
      default: s_d.count = s_q.count;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : ddpp_buf
`default_nettype wire

// File: hdl/ddpp_top.sv
// converter post-processing: registers, soft mute, mono mix, gain and control outputs
//
// The implementer's own choice: the address-and-strobe port.
`default_nettype none
module ddpp_top #(
  parameter int FS_DIV = ddpp_pkg::FS_DIV
) (
  input  wire logic                 clk,                      // 40 MHz system clock
  input  wire logic                 rst_n,                    // async reset, low
  input  wire logic [7:0]           reg_addr,                 // register address
  input  wire logic [15:0]          reg_wdata,                // write data
  input  wire logic                 reg_wr,                   // write strobe
  input  wire logic                 reg_rd,                   // read strobe
  output logic      [15:0]          reg_rdata,                // read data, cycle after strobe
  input  wire logic                 in_valid,                 // sample pair offered
  output logic                      in_ready,                 // room for a sample pair
  input  wire ddpp_pkg::ddpp_sample_t in_sample,              // incoming sample pair
  output logic                      out_valid,                // processed pair held
  input  wire logic                 out_ready,                // converter takes pair
  output ddpp_pkg::ddpp_sample_t    out_sample,               // processed pair
  output logic      [1:0]           deemphasis_rate_select,   // de-emphasis to converter
  output logic                      sloping_filter_select,    // filter type to converter
  output logic                      oversample_select,        // oversampling to converter
  output ddpp_pkg::ddpp_bias_t      bias_ctrl,                // bias fields to converter
  output logic      [11:0]          converter_bias_permille,  // effective converter bias
  output logic      [11:0]          midrail_bias_permille     // effective midrail bias
);
  typedef struct packed {
    logic [15:0] bias;
    logic [15:0] dig;
    logic [15:0] vol;
    logic [15:0] ena;
    logic [15:0] rdata;
    logic [9:0]  fs_cnt;
    logic [4:0]  ramp_cnt;
  } ddpp_top_st_t;

  ddpp_top_st_t           s_q;
  ddpp_top_st_t           s_d;
  logic                   fs_tick;
  logic                   ramp_tick;
  logic                   mute;
  logic                   left_converter_enable;
  logic                   right_converter_enable;
  logic                   mono_active;
  logic [1:0][7:0]        target;
  logic [1:0][7:0]        applied;
  logic signed [16:0]     mono_sum;
  logic signed [15:0]     mono_mix;
  ddpp_pkg::ddpp_sample_t routed;
  ddpp_pkg::ddpp_sample_t scaled;

  function automatic logic signed [15:0] ddpp_gain(input logic signed [15:0] smp, input logic [7:0] code);
    logic [7:0]         att;
    logic signed [32:0] prod;
    logic signed [32:0] shd;
    att  = (code >= ddpp_pkg::VOL_UNITY) ? 8'h00 : ddpp_pkg::VOL_UNITY - code;
    prod = 33'(smp) * $signed({17'h00000, ddpp_pkg::GAIN_MANT[att[3:0]]});
    shd  = prod >>> (16 + int'(att[7:4]));
    return (code == ddpp_pkg::VOL_SILENT) ? 16'sh0000 : shd[15:0];
  endfunction : ddpp_gain

  assign mute                   = s_q.dig[ddpp_pkg::DIG_MUTE_BIT];
  assign left_converter_enable  = s_q.ena[ddpp_pkg::ENA_LEFT_BIT];
  assign right_converter_enable = s_q.ena[ddpp_pkg::ENA_RIGHT_BIT];
  assign target[0] = s_q.vol[ddpp_pkg::VOL_LEFT_LSB +: 8];
  assign target[1] = s_q.vol[ddpp_pkg::VOL_RIGHT_LSB +: 8];

  // fs enable from the system clock, then fs/2 or fs/32 for the volume steps
  assign fs_tick   = (s_q.fs_cnt == 10'(FS_DIV - 1));
  assign ramp_tick = fs_tick && (s_q.dig[ddpp_pkg::DIG_RATE_BIT]
                     ? (s_q.ramp_cnt == 5'(ddpp_pkg::RAMP_SLOW_DIV - 1))
                     : (s_q.ramp_cnt[0] == 1'(ddpp_pkg::RAMP_FAST_DIV - 1)));

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ramp
      ddpp_ramp #(
        .RST_CODE (ddpp_pkg::VOL_UNITY)
      ) u_ramp (
        .clk                (clk),
        .rst_n              (rst_n),
        .tick               (ramp_tick),
        .mute               (mute),
        .unmute_ramp_select (s_q.dig[ddpp_pkg::DIG_MODE_BIT]),
        .target             (target[ch]),
        .applied            (applied[ch])
      );
    end
  endgenerate

  // halving the sum is the fixed 6 dB drop that keeps a full-scale pair from clipping
  assign mono_sum    = {in_sample.left[15], in_sample.left} + {in_sample.right[15], in_sample.right};
  assign mono_mix    = mono_sum[16:1];
  assign mono_active = s_q.dig[ddpp_pkg::DIG_MONO_BIT]
                       && (left_converter_enable ^ right_converter_enable);

  always_comb begin
    routed.left  = 16'sh0000;
    routed.right = 16'sh0000;
    if (left_converter_enable) begin
      routed.left = mono_active ? mono_mix : in_sample.left;
    end
    if (right_converter_enable) begin
      routed.right = mono_active ? mono_mix : in_sample.right;
    end
    scaled.left  = ddpp_gain(routed.left, applied[0]);
    scaled.right = ddpp_gain(routed.right, applied[1]);
  end

  ddpp_buf #(
    .W     ($bits(ddpp_pkg::ddpp_sample_t)),
    .DEPTH (2)
  ) u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (scaled),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_sample)
  );

  always_comb begin
    s_d = s_q;
    s_d.fs_cnt = fs_tick ? 10'h000 : s_q.fs_cnt + 10'h001;
    if (fs_tick) begin
      s_d.ramp_cnt = s_q.ramp_cnt + 5'h01;
    end
    if (reg_wr) begin
      case (reg_addr)
        ddpp_pkg::REG_BIAS: s_d.bias = reg_wdata;
        ddpp_pkg::REG_DIG:  s_d.dig  = reg_wdata;
        ddpp_pkg::REG_VOL:  s_d.vol  = reg_wdata;
        ddpp_pkg::REG_ENA:  s_d.ena  = reg_wdata;
        default:            s_d.dig  = s_q.dig;
      endcase
    end
    s_d.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        ddpp_pkg::REG_BIAS: s_d.rdata = s_q.bias;
        ddpp_pkg::REG_DIG:  s_d.rdata = s_q.dig;
        ddpp_pkg::REG_VOL:  s_d.rdata = s_q.vol;
        ddpp_pkg::REG_ENA:  s_d.rdata = s_q.ena;
        ddpp_pkg::REG_STAT: s_d.rdata = {applied[1], applied[0]};
        default:            s_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.bias     <= ddpp_pkg::BIAS_RST;
      s_q.dig      <= ddpp_pkg::DIG_RST;
      s_q.vol      <= ddpp_pkg::VOL_RST;
      s_q.ena      <= ddpp_pkg::ENA_RST;
      s_q.rdata    <= 16'h0000;
      s_q.fs_cnt   <= 10'h000;
      s_q.ramp_cnt <= 5'h00;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata              = s_q.rdata;
  assign deemphasis_rate_select = s_q.dig[ddpp_pkg::DIG_DEEMPHASIS_RATE_SELECT_LSB +: 2];
  assign sloping_filter_select  = s_q.dig[ddpp_pkg::DIG_SBF_BIT];
  assign oversample_select      = s_q.dig[ddpp_pkg::DIG_OSR_BIT];
  assign bias_ctrl.boost                     = s_q.bias[ddpp_pkg::BIAS_BOOST_BIT];
  assign bias_ctrl.converter_bias_level      = s_q.bias[ddpp_pkg::BIAS_SEL_LSB +: 2];
  assign bias_ctrl.midrail_buffer_bias_level = s_q.bias[ddpp_pkg::BIAS_VMID_LSB +: 2];
  // boost doubles whichever reduced level is chosen, it does not replace it
  assign converter_bias_permille = ddpp_pkg::BIAS_PERMILLE[bias_ctrl.converter_bias_level]
                                   << bias_ctrl.boost;
  assign midrail_bias_permille   = ddpp_pkg::BIAS_PERMILLE[bias_ctrl.midrail_buffer_bias_level]
                                   << bias_ctrl.boost;
endmodule : ddpp_top
`default_nettype wire

// File: verif/ddpp_chk.sv
// assertion checker for the converter post-processing block
`default_nettype none
module ddpp_chk #(
  parameter int FS_DIV = 4
) (
  input wire logic                 clk,                     // clock
  input wire logic                 rst_n,                   // async reset, low
  input wire logic [7:0]           reg_addr,                // address
  input wire logic [15:0]          reg_wdata,               // write data
  input wire logic                 reg_wr,                  // write strobe
  input wire logic                 reg_rd,                  // read strobe
  input wire logic [15:0]          reg_rdata,               // read data
  input wire logic                 in_valid,                // pair offered
  input wire logic                 in_ready,                // room for a pair
  input wire logic                 out_valid,               // pair held
  input wire logic [1:0]           deemphasis_rate_select,  // de-emphasis
  input wire logic                 sloping_filter_select,   // filter type
  input wire ddpp_pkg::ddpp_bias_t bias_ctrl,               // bias fields
  input wire logic [11:0]          converter_bias_permille, // converter bias
  input wire logic [11:0]          midrail_bias_permille    // midrail bias
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] dig_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) dig_q <= 16'h0000;
    else if (reg_wr && reg_addr == ddpp_pkg::REG_DIG) dig_q <= reg_wdata;
  end
  dig_readback_a: assert property (reg_rd && reg_addr == ddpp_pkg::REG_DIG |=> reg_rdata == dig_q)
    else $error("digital control readback differs");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside its slot");
  deemphasis_rate_select_follow_a: assert property (
    reg_wr && reg_addr == ddpp_pkg::REG_DIG |=> deemphasis_rate_select == $past(reg_wdata[2:1]))
    else $error("de-emphasis output differs");
  filter_follow_a: assert property (
    reg_wr && reg_addr == ddpp_pkg::REG_DIG |=> sloping_filter_select == $past(reg_wdata[11]))
    else $error("filter select differs");
  bias_follow_a: assert property (
    reg_wr && reg_addr == ddpp_pkg::REG_BIAS |=> bias_ctrl == $past(reg_wdata[5:1]))
    else $error("bias fields differ");
  conv_bias_a: assert property (
    converter_bias_permille == ddpp_pkg::BIAS_PERMILLE[bias_ctrl.converter_bias_level] << bias_ctrl.boost)
    else $error("converter bias level wrong");
  midrail_bias_a: assert property (
    midrail_bias_permille == ddpp_pkg::BIAS_PERMILLE[bias_ctrl.midrail_buffer_bias_level] << bias_ctrl.boost)
    else $error("midrail bias level wrong");
  push_answer_a: assert property (in_valid && in_ready |=> out_valid)
    else $error("accepted pair not offered");
  cover property (reg_wr && reg_addr == ddpp_pkg::REG_DIG && reg_wdata[3]);
  cover property (reg_wr && reg_addr == ddpp_pkg::REG_BIAS && reg_wdata[5]);
  cover property (in_valid && !in_ready);
endmodule : ddpp_chk
`default_nettype wire

// File: verif/ddpp_sink.sv
// converter-side sink model: takes processed pairs and can stall
`default_nettype none
module ddpp_sink (
  input wire logic                   clk,        // clock
  input wire logic                   stall,      // hold off the buffer
  input wire logic                   out_valid,  // pair held
  input wire ddpp_pkg::ddpp_sample_t out_sample, // pair
  output logic                       out_ready   // takes pair
);
  timeunit 1ns;
  timeprecision 1ps;
  ddpp_pkg::ddpp_sample_t got[$];
  logic rdy_q = 1'b0;
  assign out_ready = rdy_q;
  always @(posedge clk) begin
    if (out_valid && out_ready) got.push_back(out_sample);
    rdy_q <= !stall;
  end
endmodule : ddpp_sink
`default_nettype wire

// File: verif/ddpp_top_tb.sv
// self-checking bench for the converter post-processing block
`default_nettype none
module ddpp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FS_DIV = 4;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, in_valid = 1'b0, stall = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic in_ready, out_valid, out_ready, sloping_filter_select, oversample_select;
  ddpp_pkg::ddpp_sample_t in_sample = '0, out_sample;
  logic [1:0] deemphasis_rate_select;
  ddpp_pkg::ddpp_bias_t bias_ctrl;
  logic [11:0] converter_bias_permille, midrail_bias_permille;
  logic [11:0] tbl [4] = '{12'h3e8, 12'h1f4, 12'h294, 12'h2ee};
  int error_cnt = 0;
  int samples_checked = 0;
  always #12.5 clk = ~clk;
  ddpp_top #(.FS_DIV(FS_DIV)) DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready),
    .in_sample(in_sample), .out_valid(out_valid), .out_ready(out_ready), .out_sample(out_sample),
    .deemphasis_rate_select(deemphasis_rate_select), .sloping_filter_select(sloping_filter_select),
    .oversample_select(oversample_select), .bias_ctrl(bias_ctrl),
    .converter_bias_permille(converter_bias_permille), .midrail_bias_permille(midrail_bias_permille));
  ddpp_sink u_sink (.clk(clk), .stall(stall), .out_valid(out_valid), .out_sample(out_sample), .out_ready(out_ready));
  task automatic tally_and_finish();
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic timeout();
    error_cnt++;
    tally_and_finish();
  endtask : timeout
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // unity code still loses one step of the 16-bit gain fraction
  function automatic logic [15:0] unity(input logic signed [15:0] x);
    logic signed [31:0] p;
    p = x * 32'sd65535;
    return p[31:16];
  endfunction : unity
  function automatic logic [15:0] mono(input logic [15:0] l, input logic [15:0] r);
    logic [16:0] s;
    s = {l[15], l} + {r[15], r};
    return unity(s[16:1]);
  endfunction : mono
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rchk
  task automatic send(input logic [31:0] s);
    @(posedge clk);
    in_valid <= 1'b1;
    in_sample <= s;
    @(negedge clk);
    for (int n = 0; in_ready !== 1'b1; n++) begin
      if (n == 60) timeout();
      @(negedge clk);
    end
    @(posedge clk);
    in_valid <= 1'b0;
    in_sample <= ~s;
  endtask : send
  task automatic expect_pair(input logic [31:0] e);
    for (int n = 0; u_sink.got.size() == 0; n++) begin
      if (n == 60) timeout();
      @(negedge clk);
    end
    chk(u_sink.got.pop_front(), e);
  endtask : expect_pair
  // polls the applied codes; the ramp phase at the write is unknown, so allow one step early
  task automatic ramp(input logic [15:0] dig, input logic [15:0] stat, input int exp, input int per);
    int n;
    logic [15:0] d;
    wr(ddpp_pkg::REG_DIG, dig);
    n = 0;
    do begin
      rd(ddpp_pkg::REG_STAT, d);
      n += 2;
      if (n > exp + 200) timeout();
    end while (d !== stat);
    chk(n >= exp - per && n <= exp + 6, 1);
  endtask : ramp
  task automatic t_reset();
    rchk(ddpp_pkg::REG_DIG, 16'h0000);
    rchk(ddpp_pkg::REG_BIAS, 16'h0000);
    rchk(ddpp_pkg::REG_VOL, 16'hc0c0);
    rchk(ddpp_pkg::REG_ENA, 16'h0003);
    wr(ddpp_pkg::REG_STAT, 16'h1234);
    rchk(ddpp_pkg::REG_STAT, 16'hc0c0);
    rchk(8'h30, 16'h0000);
    chk(converter_bias_permille, 12'h3e8);
  endtask : t_reset
  task automatic t_bias();
    logic [1:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[1:0];
      wr(ddpp_pkg::REG_BIAS, {10'h000, i[2], c, ~c, 1'b0});
      @(negedge clk);
      chk(bias_ctrl, {i[2], c, ~c});
      chk(converter_bias_permille, tbl[c] << i[2]);
      chk(midrail_bias_permille, tbl[~c] << i[2]);
    end
  endtask : t_bias
  task automatic t_ctrl();
    for (int m = 0; m < 4; m++) begin
      wr(ddpp_pkg::REG_DIG, {4'h0, m[0], 8'h00, m[1:0], m[1]});
      @(negedge clk);
      chk(deemphasis_rate_select, m[1:0]);
      chk(sloping_filter_select, m[0]);
      chk(oversample_select, m[1]);
    end
  endtask : t_ctrl
  task automatic t_stream();
    wr(ddpp_pkg::REG_DIG, 16'h1000);
    stall <= 1'b1;
    send(32'h1000f800);
    send(32'h7fff8000);
    fork
      send(32'h0001ffff);
      begin
        repeat (6) @(negedge clk);
        chk(in_ready, 0);
        @(posedge clk);
        stall <= 1'b0;
      end
    join
    expect_pair({unity(16'h1000), unity(16'hf800)});
    expect_pair({unity(16'h7fff), unity(16'h8000)});
    expect_pair({unity(16'h0001), unity(16'hffff)});
  endtask : t_stream
  task automatic t_mono();
    wr(ddpp_pkg::REG_ENA, 16'h0002);
    send(32'h40003000);
    expect_pair({mono(16'h4000, 16'h3000), 16'h0000});
    wr(ddpp_pkg::REG_ENA, 16'h0001);
    send(32'h80008000);
    expect_pair({16'h0000, mono(16'h8000, 16'h8000)});
  endtask : t_mono
  task automatic t_ramp();
    ramp(16'h0208, 16'h0000, 192 * 2 * FS_DIV, 2 * FS_DIV);
    ramp(16'h0200, 16'hc0c0, 192 * 2 * FS_DIV, 2 * FS_DIV);
    ramp(16'h0408, 16'h0000, 192 * 32 * FS_DIV, 32 * FS_DIV);
    ramp(16'h0000, 16'hc0c0, 2, 2);
    wr(ddpp_pkg::REG_VOL, 16'h6060);
    ramp(16'h0008, 16'h0000, 96 * 2 * FS_DIV, 2 * FS_DIV);
    send(32'h40003000);
    expect_pair(32'h00000000);
  endtask : t_ramp
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_bias();
    t_ctrl();
    t_stream();
    t_mono();
    t_ramp();
    tally_and_finish();
  end
endmodule : ddpp_top_tb
bind ddpp_top ddpp_chk #(.FS_DIV(FS_DIV)) u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
  .in_ready(in_ready), .out_valid(out_valid), .deemphasis_rate_select(deemphasis_rate_select),
  .sloping_filter_select(sloping_filter_select), .bias_ctrl(bias_ctrl),
  .converter_bias_permille(converter_bias_permille), .midrail_bias_permille(midrail_bias_permille));
`default_nettype wire
